// ---- hdl/scrs_rom_select.sv ----
// Purpose: rom level selection, resume and overdrive control
// Assumes: timing generator decodes slots; line sampled via lineRaw and lineDeep
// Notes: line front end filters glitches before slot timing uses it
`timescale 1ns/1ps
module scrs_rom_select #(
  parameter logic [63:0] RomId = 64'h0123_4567_89ab_cd01, // arbitrary
  parameter int LongResetCycles = scrs_pkg::LongResetCyc
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic lineRaw,
  input wire logic lineDeep,
  input wire scrs_pkg::scrs_slot_t slotIn,
  output scrs_pkg::scrs_status_t status,
  output logic lineSeen
);
  import scrs_pkg::*;

  typedef struct packed {
    scrs_state_t st;
    logic [7:0] cmd;
    logic [6:0] cnt;
    logic [1:0] phase;
    logic isOdMatch;
    logic [2:0] syncRaw;
    logic [2:0] syncDeep;
    logic lineLow;
    logic [15:0] hold;
    scrs_status_t out;
  } scrs_reg_t;

  scrs_reg_t q, d;
  logic [1:0] rstSync;
  logic rstInt;
  logic idBit;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstInt = rstSync[1];
  assign idBit = RomId[q.cnt[5:0]];

  always_comb begin
    d = q;
    d.syncRaw = {q.syncRaw[1:0], lineRaw};
    d.syncDeep = {q.syncDeep[1:0], lineDeep};
    d.out.sendValid = 1'b0;
    // low only once below the hysteresis band; rise at threshold
    if (q.lineLow) begin
      if (q.syncRaw[2] && q.syncRaw[1]) begin
        d.lineLow = 1'b0;
        d.hold = 16'(HoldoffCyc);
      end
    end else if (q.hold != 16'h0) begin
      // any dip inside the window is ignored
      d.hold = q.hold - 16'h1;
    end else if (!q.syncDeep[2] && !q.syncDeep[1]) begin
      d.lineLow = 1'b1; // late or lasting low opens a slot
    end
    if (slotIn.resetSeen) begin
      d.st = ScCmd;
      d.cnt = 7'h0;
      d.out.funcActive = 1'b0;
      if (slotIn.resetLong) begin
        d.out.overdrive = 1'b0;
      end
    end else if (slotIn.slotValid) begin
      case (q.st)
        ScCmd: begin
          d.cmd = {slotIn.slotBit, q.cmd[7:1]};
          d.cnt = q.cnt + 7'h1;
          if (q.cnt == 7'(CmdBits - 1)) begin
            d.cnt = 7'h0;
            d.phase = 2'h0;
            case (d.cmd)
              CmdSkip: begin
                d.st = ScFunc;
              end
              CmdOdSkip: begin
                d.st = ScFunc;
                d.out.overdrive = 1'b1;
              end
              CmdResume: begin
                // flag clear: silent until reset
                d.st = q.out.resumeFlag ? ScFunc : ScWait;
              end
              CmdMatch: begin
                d.st = ScMatch;
                d.isOdMatch = 1'b0;
              end
              CmdOdMatch: begin
                d.st = ScMatch;
                d.isOdMatch = 1'b1;
              end
              CmdSearch: begin
                d.st = ScSearch;
                d.out.sendBit = idBit;
                d.out.sendValid = 1'b1;
              end
              default: begin
                d.st = ScWait;
              end
            endcase
          end
        end
        ScMatch: begin
          d.cnt = q.cnt + 7'h1;
          if (slotIn.slotBit != idBit) begin
            // prior overdrive untouched
            d.out.resumeFlag = 1'b0;
            d.st = ScWait;
          end else if (q.cnt == 7'(IdBits - 1)) begin
            d.st = ScFunc;
            d.out.resumeFlag = 1'b1;
            if (q.isOdMatch) begin
              d.out.overdrive = 1'b1;
            end
          end
        end
        ScSearch: begin
          d.phase = q.phase + 2'h1;
          if (q.phase == 2'h0) begin
            d.out.sendBit = ~idBit;
            d.out.sendValid = 1'b1;
          end else if (q.phase == 2'h2) begin
            d.phase = 2'h0;
            d.cnt = q.cnt + 7'h1;
            if (slotIn.slotBit != idBit) begin
              d.out.resumeFlag = 1'b0;
              d.st = ScWait;
            end else if (q.cnt == 7'(IdBits - 1)) begin
              d.st = ScFunc;
              d.out.resumeFlag = 1'b1;
            end else begin
              d.out.sendBit = RomId[6'(q.cnt + 7'h1)];
              d.out.sendValid = 1'b1;
            end
          end
        end
        ScFunc, ScWait, ScIdle, ScRead: begin
          d.st = q.st;
        end
        default: begin
          d.st = ScWait;
        end
      endcase
    end
    d.out.funcActive = (d.st == ScFunc);
  end

  always_ff @(posedge clk_sys or negedge rstInt) begin
    if (!rstInt) begin
      q <= '{st: ScIdle, cmd: 8'h0, cnt: 7'h0, phase: 2'h0,
             isOdMatch: 1'b0, syncRaw: 3'h7, syncDeep: 3'h7,
             lineLow: 1'b0, hold: 16'h0,
             out: '{funcActive: 1'b0, overdrive: overdriveFlagRst,
                    resumeFlag: resumeFlagRst, sendBit: 1'b0,
                    sendValid: 1'b0}};
    end else begin
      q <= d;
    end
  end

  assign status = q.out;
  assign lineSeen = q.lineLow;

  // last command slot carrying the given code, gated by an extra term
  sequence cmdEndS(logic [7:0] code, logic gate);
    q.st == ScCmd && slotIn.slotValid && !slotIn.resetSeen
      && q.cnt == 7'(CmdBits - 1) && d.cmd == code && gate;
  endsequence

  skip_func_a: assert property (
    @(posedge clk_sys) disable iff (!rstInt)
    cmdEndS(CmdSkip, 1'b1) |=> q.out.funcActive)
    else $error("skip did not enter function phase");
  od_skip_a: assert property (
    @(posedge clk_sys) disable iff (!rstInt)
    cmdEndS(CmdOdSkip, 1'b1) |=> q.out.overdrive)
    else $error("overdrive skip did not set overdrive");
  long_reset_a: assert property (
    @(posedge clk_sys) disable iff (!rstInt)
    (slotIn.resetSeen && slotIn.resetLong) |=> !q.out.overdrive)
    else $error("long reset kept overdrive");
  resume_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rstInt)
    cmdEndS(CmdResume, !q.out.resumeFlag) |=> q.st == ScWait)
    else $error("resume with clear flag answered");
  resume_set_a: assert property (
    @(posedge clk_sys) disable iff (!rstInt)
    $rose(q.out.resumeFlag) |-> $past(q.st) inside {ScMatch, ScSearch})
    else $error("resume flag set by wrong command");
  mismatch_a: assert property (
    @(posedge clk_sys) disable iff (!rstInt)
    (q.st == ScMatch && slotIn.slotValid && !slotIn.resetSeen
     && slotIn.slotBit != idBit) |=> (!q.out.resumeFlag && q.st == ScWait))
    else $error("mismatch did not drop out");
  search_comp_a: assert property (
    @(posedge clk_sys) disable iff (!rstInt)
    (q.st == ScSearch && q.phase == 2'h0 && slotIn.slotValid
     && !slotIn.resetSeen)
    |=> (q.out.sendValid && q.out.sendBit == !$past(idBit)))
    else $error("search complement bit wrong");
  od_keep_a: assert property (
    @(posedge clk_sys) disable iff (!rstInt)
    (q.st == ScMatch && q.out.overdrive && !slotIn.resetSeen)
    |=> q.out.overdrive)
    else $error("overdrive lost during match");
  // whole window of HoldoffCyc cycles after the release
  holdoff_a: assert property (
    @(posedge clk_sys) disable iff (!rstInt)
    $fell(q.lineLow) |=> !q.lineLow [*5])
    else $error("low seen inside holdoff window");
  wait_stay_a: assert property (
    @(posedge clk_sys) disable iff (!rstInt)
    (q.st == ScWait && !slotIn.resetSeen) |=> q.st == ScWait)
    else $error("left wait without reset");
endmodule

// ---- hdl/scrs_pkg.sv ----
// Purpose: shared constants and types for the single contact rom select
// Assumes: 10 MHz system clock
// Notes: command codes, timing windows, state layout
package scrs_pkg;
  localparam int ClkMhz = 10;
  localparam logic [7:0] CmdMatch = 8'h55;
  localparam logic [7:0] CmdSearch = 8'hf0;
  localparam logic [7:0] CmdSkip = 8'hcc;
  localparam logic [7:0] CmdResume = 8'ha5;
  localparam logic [7:0] CmdOdSkip = 8'h3c;
  localparam logic [7:0] CmdOdMatch = 8'h69;
  localparam int CmdBits = 8;
  localparam int IdBits = 64;
  // long reset, in microseconds
  localparam int LongResetUs = 480;
  localparam int LongResetCyc = LongResetUs * ClkMhz;
  // rising edge holdoff window, in nanoseconds
  localparam int HoldoffNs = 500;
  localparam int HoldoffCyc =
    (HoldoffNs * ClkMhz + 999) / 1000 < 1 ? 1 :
    (HoldoffNs * ClkMhz + 999) / 1000;
  localparam logic resumeFlagRst = 1'b0;
  localparam logic overdriveFlagRst = 1'b0;

  typedef enum logic [6:0] {
    ScIdle = 7'h01,
    ScCmd = 7'h02,
    ScMatch = 7'h04,
    ScSearch = 7'h08,
    ScFunc = 7'h10,
    ScWait = 7'h20,
    ScRead = 7'h40
  } scrs_state_t;

  // one time slot or reset as seen by the timing generator
  typedef struct packed {
    logic slotValid;
    logic slotBit;
    logic resetSeen;
    logic resetLong;
  } scrs_slot_t;

  typedef struct packed {
    logic funcActive;
    logic overdrive;
    logic resumeFlag;
    logic sendBit;
    logic sendValid;
  } scrs_status_t;
endpackage

// ---- tb/scrs_bus_master.sv ----
// Purpose: bus master stand-in giving decoded slots and resets
// Assumes: timing generator already turned line activity into events
// Notes: idle slot bit is inverted so a stale value never passes
`timescale 1ns/1ps
module scrs_bus_master (
  input wire logic clk_sys,
  output scrs_pkg::scrs_slot_t slotOut
);
  import scrs_pkg::*;
  initial slotOut = '0;
  task automatic busReset(input logic isLong);
    @(negedge clk_sys);
    slotOut <= '{1'b0, 1'b0, 1'b1, isLong};
    @(negedge clk_sys);
    slotOut <= '{1'b0, ~isLong, 1'b0, 1'b0};
  endtask
  // one slot: valid for a cycle, then idle for a cycle
  task automatic sendSlot(input logic b);
    @(negedge clk_sys);
    slotOut <= '{1'b1, b, 1'b0, 1'b0};
    @(negedge clk_sys);
    slotOut <= '{1'b0, ~b, 1'b0, 1'b0};
  endtask
  // lsb first, back to back
  task automatic sendBits(input logic [63:0] val);
    for (int i = 0; i < 64; i++) begin
      sendSlot(val[i]);
    end
  endtask
  // always whole eight bit units
  task automatic sendCmd(input logic [7:0] cmd);
    for (int i = 0; i < 8; i++) begin
      sendSlot(cmd[i]);
    end
  endtask
endmodule

// ---- tb/tb_scrs_rom_select.sv ----
// Purpose: self-checking bench for rom selection and line filter
// Assumes: single slave on the bus, model drives slot events
// Notes: status checked as {funcActive, overdrive, resumeFlag}
`timescale 1ns/1ps
module tb_scrs_rom_select;
  import scrs_pkg::*;
  localparam logic [63:0] TbId = 64'h5a3c_0f96_e1d2_7b48; // arbitrary
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic lineRaw = 1'b1;
  logic lineDeep = 1'b1;
  scrs_slot_t slotIn;
  scrs_status_t status;
  logic lineSeen;
  int err_count = 0;
  int check_count = 0;
  always #50 clk_sys = ~clk_sys;
  scrs_bus_master i_scrs_bus_master (
    .clk_sys(clk_sys),
    .slotOut(slotIn)
  );
  scrs_rom_select #(.RomId(TbId)) i_scrs_rom_select (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .lineRaw(lineRaw),
    .lineDeep(lineDeep),
    .slotIn(slotIn),
    .status(status),
    .lineSeen(lineSeen)
  );
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkStat(input logic [2:0] exp);
    @(negedge clk_sys);
    chk({status.funcActive, status.overdrive, status.resumeFlag}, exp);
  endtask
  // sampled at the falling edge after the slot that launched it
  task automatic chkSend(input logic [1:0] exp);
    chk({1'b0, status.sendValid, status.sendBit}, {1'b0, exp});
  endtask
  task automatic sel(input logic isLong, input logic [7:0] cmd);
    i_scrs_bus_master.busReset(isLong);
    i_scrs_bus_master.sendCmd(cmd);
  endtask
  task automatic t_skip();
    sel(1'b1, CmdSkip);
    chkStat(3'b100);
    $display("test skip done");
  endtask
  task automatic t_match();
    sel(1'b1, CmdResume);
    chkStat(3'b000);
    i_scrs_bus_master.sendCmd(CmdSkip);
    chkStat(3'b000);
    sel(1'b1, CmdMatch);
    i_scrs_bus_master.sendBits(TbId);
    chkStat(3'b101);
    for (int i = 0; i < 2; i++) begin
      sel(1'b1, CmdResume);
      chkStat(3'b101);
    end
    sel(1'b1, CmdMatch);
    i_scrs_bus_master.sendBits(TbId ^ 64'h8000_0000_0000_0000);
    chkStat(3'b000);
    sel(1'b1, CmdResume);
    chkStat(3'b000);
    $display("test match done");
  endtask
  task automatic t_overdrive();
    sel(1'b1, CmdOdSkip);
    chkStat(3'b110);
    sel(1'b0, CmdOdMatch);
    i_scrs_bus_master.sendBits(~TbId);
    chkStat(3'b010);
    i_scrs_bus_master.busReset(1'b1);
    chkStat(3'b000);
    sel(1'b1, CmdOdMatch);
    i_scrs_bus_master.sendBits(TbId);
    chkStat(3'b111);
    sel(1'b1, CmdResume);
    chkStat(3'b101);
    $display("test overdrive done");
  endtask
  task automatic t_filter();
    @(negedge clk_sys);
    lineRaw = 1'b0;
    lineDeep = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk({2'b00, lineSeen}, 3'b001);
    lineRaw = 1'b1;
    lineDeep = 1'b1;
    @(negedge clk_sys);
    lineDeep = 1'b0;
    repeat (2) @(negedge clk_sys);
    lineDeep = 1'b1;
    repeat (8) begin
      @(negedge clk_sys);
      chk({2'b00, lineSeen}, 3'b000);
    end
    lineRaw = 1'b0;
    repeat (10) begin
      @(negedge clk_sys);
      chk({2'b00, lineSeen}, 3'b000);
    end
    lineDeep = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk({2'b00, lineSeen}, 3'b001);
    lineRaw = 1'b1;
    lineDeep = 1'b1;
    $display("test filter done");
  endtask
  task automatic t_search();
    sel(1'b1, CmdSearch);
    chkSend({1'b1, TbId[0]});
    i_scrs_bus_master.sendSlot(1'b1);
    chkSend({1'b1, ~TbId[0]});
    i_scrs_bus_master.sendSlot(1'b1);
    i_scrs_bus_master.sendSlot(~TbId[0]);
    chkStat(3'b000);
    sel(1'b1, CmdSearch);
    for (int i = 0; i < 64; i++) begin
      chkSend({1'b1, TbId[i]});
      i_scrs_bus_master.sendSlot(1'b1);
      chkSend({1'b1, ~TbId[i]});
      i_scrs_bus_master.sendSlot(1'b1);
      chkSend({1'b0, ~TbId[i]});
      i_scrs_bus_master.sendSlot(TbId[i]);
    end
    chkStat(3'b101);
    $display("test search done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // about 1200 cycles of traffic, so 3000 cycles means a hang
  initial begin
    #300000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chkStat(3'b000);
    t_skip();
    t_match();
    t_overdrive();
    t_filter();
    t_search();
    stop_test();
  end
endmodule
